//--- hw/dram_mode_config_params.svh
`ifndef DRAM_MODE_CONFIG_PARAMS_SVH
`define DRAM_MODE_CONFIG_PARAMS_SVH

// ----------------------------------------------------------------------------
// Timing configuration register fields
// ----------------------------------------------------------------------------
`define CFG_PAGE_SIZE_LSB 0
`define CFG_PAGE_SIZE_MSB 1
`define CFG_INTERLEAVE_BIT 2
`define CFG_NEAR_OVERRIDE_BIT 3
`define CFG_ROW_COL_DELAY_BIT 4
`define CFG_RESET_VALUE 16'h0000

// ----------------------------------------------------------------------------
// Page size encodings
// ----------------------------------------------------------------------------
`define PAGE_256K 2'h0
`define PAGE_1M 2'h1

// ----------------------------------------------------------------------------
// Access timeline, in half cycles of the processor bus clock
// ----------------------------------------------------------------------------
`define COL_ADDR_STEP_FAST 4'h1
`define COL_ADDR_STEP_SLOW 4'h3
`define COL_STROBE_STEP_FAST 4'h2
`define COL_STROBE_STEP_SLOW 4'h4
`define READ_STROBE_HALVES 4'h3
`define NEAR_WRITE_FAST_HALVES 4'h4
`define NEAR_WRITE_SLOW_HALVES 4'h6

`endif

//--- hw/dram_mode_config_pkg.sv
`default_nettype none

package dram_mode_config_pkg;

  // Processor bus pins after synchronisation
  typedef struct packed {
    logic [25:0] ad;
    logic ale;
    logic rd_n;
    logic wr_n;
    logic near_write_hint_n;
    logic cs_n;
    logic msel_n;
    logic [3:0] byte_en_n;
  } cpu_bus_t;

  // Access sequencer states
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_ACCESS = 4'b0010,
    S_MODE = 4'b0100,
    S_END = 4'b1000
  } seq_state_t;

endpackage

`default_nettype wire

//--- hw/dram_mode_config_datapath.sv
// Operation
// [R1] Decodes 64 MByte space; acts only while its chip select is asserted.
// [R2] One direction output steers every data transceiver together.
// [R3] Four active-low lane enables, one per byte-lane buffer.
// [R4] Path select steers exchangers; one latch enable drives both latches.
// [R5] Two-bit page size picks device size; 00 means 256K x 4.
// [R6] Interleave bit picks interleaving and buffer type; 0 is plain.
// [R7] Override set: ignore near hint, writes take three cycles, else two.
// [R8] Row-to-column delay in cycles; setting 0 gives one cycle.
// [R9] Setting 0: address turns to column half a cycle after row strobe.
// [R10] Reads negate column strobes on the edge where data is sampled.
// [R11] Column strobe lasts at least one and a half cycles.
// [R12] Processor keeps clock period regular; only phase widths vary.
// [R13] Mode write value arrives on low sixteen address/data lines.
// [R14] Decoder asserts chip and mode select for mode writes only.
// [R15] Access address is captured with the address latch enable strobe.
// [R16] Configuration holds between writes; new values apply to later accesses.
`include "dram_mode_config_params.svh"
`default_nettype none

module dram_mode_config_datapath (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Processor bus pins
  input wire logic [25:0] ad,
  input wire logic ale,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic near_write_hint_n,
  input wire logic cs_n,
  input wire logic msel_n,
  input wire logic [3:0] byte_en_n,
  output logic ack_n,
  // DRAM side
  output logic row_strobe_n,
  output logic [3:0] col_strobe_n,
  output logic write_strobe_n,
  output logic [10:0] dram_address_out,
  // Data path
  output logic buffer_transmit,
  output logic [3:0] byte_lane_buffer_enable_n,
  output logic path_select,
  output logic exchanger_latch_enable
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------

  // Row or column slice of the word address for the chosen device size
  function automatic logic [10:0] dram_addr(input logic [23:0] word, input logic [1:0] size,
                                            input logic col);
    logic [10:0] r;
    begin
      unique case (size)
        `PAGE_256K: r = col ? {2'h0, word[8:0]} : {2'h0, word[17:9]};
        `PAGE_1M: r = col ? {1'h0, word[9:0]} : {1'h0, word[19:10]};
        default: r = col ? word[10:0] : word[21:11];
      endcase
      return r;
    end
  endfunction

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  dram_mode_config_pkg::cpu_bus_t pin_meta;
  dram_mode_config_pkg::cpu_bus_t pin;

  // Two stages: the bus pins are asynchronous to clk_sys
  always_ff @(posedge clk_sys) begin
    pin_meta <= '{ad: ad, ale: ale, rd_n: rd_n, wr_n: wr_n,
                  near_write_hint_n: near_write_hint_n, cs_n: cs_n, msel_n: msel_n,
                  byte_en_n: byte_en_n};
    pin <= pin_meta;
  end

  // --------------------------------------------------------------------------
  // Address capture
  // --------------------------------------------------------------------------
  logic [25:0] addr_q;
  logic [3:0] lanes_q;
  logic selected;
  logic mode_target;

  // Latch address and selects while the strobe is high; the last value stands
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      addr_q <= 26'h0000000;
      lanes_q <= 4'hF;
      selected <= 1'b0;
      mode_target <= 1'b0;
    end else if (pin.ale) begin
      addr_q <= pin.ad; // [R15]
      lanes_q <= pin.byte_en_n;
      selected <= ~pin.cs_n; // [R1]
      mode_target <= ~pin.cs_n & ~pin.msel_n; // [R14]
    end
  end

  // --------------------------------------------------------------------------
  // Timing configuration register
  // --------------------------------------------------------------------------
  logic [15:0] timing_configuration;
  logic [15:0] mode_data;
  dram_mode_config_pkg::seq_state_t state;

  // Track data lines during the write; store when the write strobe lifts
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mode_data <= `CFG_RESET_VALUE;
      timing_configuration <= `CFG_RESET_VALUE;
    end else if (state == dram_mode_config_pkg::S_MODE) begin
      if (!pin.wr_n) begin
        mode_data <= pin.ad[15:0]; // [R13]
      end else begin
        timing_configuration <= mode_data; // [R16]
      end
    end
  end

  // --------------------------------------------------------------------------
  // Access sequencer
  // --------------------------------------------------------------------------
  logic [3:0] step;
  logic is_write;
  logic fast_write;
  logic [1:0] page_size_field;
  logic interleave;
  logic row_col_delay_sel;
  logic [3:0] col_addr_step;
  logic [3:0] col_step;
  logic [3:0] end_step;
  logic start_access;
  logic start_mode;

  // Snapshot of the fields so a mode write never disturbs a running access
  assign col_addr_step = row_col_delay_sel ? `COL_ADDR_STEP_SLOW : `COL_ADDR_STEP_FAST; // [R9]
  assign col_step = row_col_delay_sel ? `COL_STROBE_STEP_SLOW : `COL_STROBE_STEP_FAST; // [R8]
  assign end_step = col_step + (!is_write ? `READ_STROBE_HALVES : // [R11]
                    (fast_write ? `NEAR_WRITE_FAST_HALVES : `NEAR_WRITE_SLOW_HALVES)); // [R7]
  assign start_access = selected & ~mode_target & ~pin.ale & (~pin.rd_n | ~pin.wr_n); // [R1]
  assign start_mode = mode_target & ~pin.ale & ~pin.wr_n; // [R14]

  // State and half-cycle step counter; each clk_sys edge is one bus half cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state <= dram_mode_config_pkg::S_IDLE;
      step <= 4'h0;
    end else begin
      unique case (state)
        dram_mode_config_pkg::S_IDLE: begin
          step <= 4'h0;
          if (start_mode) begin
            state <= dram_mode_config_pkg::S_MODE;
          end else if (start_access) begin
            state <= dram_mode_config_pkg::S_ACCESS;
          end
        end
        dram_mode_config_pkg::S_ACCESS: begin
          step <= step + 4'h1;
          if (step == end_step) begin
            state <= dram_mode_config_pkg::S_END;
          end
        end
        dram_mode_config_pkg::S_MODE: begin
          if (pin.wr_n) begin
            state <= dram_mode_config_pkg::S_END;
          end
        end
        dram_mode_config_pkg::S_END: begin
          if (pin.rd_n & pin.wr_n) begin
            state <= dram_mode_config_pkg::S_IDLE;
          end
        end
      endcase
    end
  end

  // Fields and access kind are frozen at access start
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      is_write <= 1'b0;
      fast_write <= 1'b0;
      page_size_field <= `PAGE_256K;
      interleave <= 1'b0;
      row_col_delay_sel <= 1'b0;
    end else if (state == dram_mode_config_pkg::S_IDLE && start_access) begin
      is_write <= ~pin.wr_n;
      // Hint is honoured only while the override is clear
      fast_write <= ~pin.near_write_hint_n &
                    ~timing_configuration[`CFG_NEAR_OVERRIDE_BIT]; // [R7]
      page_size_field <= timing_configuration[`CFG_PAGE_SIZE_MSB:`CFG_PAGE_SIZE_LSB]; // [R5]
      interleave <= timing_configuration[`CFG_INTERLEAVE_BIT]; // [R6]
      row_col_delay_sel <= timing_configuration[`CFG_ROW_COL_DELAY_BIT]; // [R16]
    end
  end

  // --------------------------------------------------------------------------
  // DRAM strobes and address
  // --------------------------------------------------------------------------
  logic in_access;
  logic col_phase;
  logic addr_col;

  assign in_access = (state == dram_mode_config_pkg::S_ACCESS);
  // Outputs are registered one edge after the step, so compare the step itself
  assign col_phase = in_access & (step >= col_step) & (step != end_step); // [R8]
  assign addr_col = in_access & (step >= col_addr_step); // [R9]

  // Registered strobes; column strobe is released (rises) on the same edge as the ack falls
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      row_strobe_n <= 1'b1;
      col_strobe_n <= 4'hF;
      write_strobe_n <= 1'b1;
      ack_n <= 1'b1;
      dram_address_out <= 11'h000;
    end else begin
      row_strobe_n <= ~(in_access & (step != end_step));
      col_strobe_n <= col_phase ? lanes_q : 4'hF; // [R10]
      write_strobe_n <= ~(col_phase & is_write);
      ack_n <= ~(in_access & (step == end_step)); // [R10]
      dram_address_out <= dram_addr(addr_q[25:2], page_size_field, addr_col); // [R9]
    end
  end

  // --------------------------------------------------------------------------
  // Data path control
  // --------------------------------------------------------------------------

  // Buffers stay open across the whole access so read data flows straight through
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      buffer_transmit <= 1'b0;
      byte_lane_buffer_enable_n <= 4'hF;
      path_select <= 1'b0;
      exchanger_latch_enable <= 1'b1;
    end else begin
      buffer_transmit <= in_access & is_write; // [R2]
      byte_lane_buffer_enable_n <= in_access ? lanes_q : 4'hF; // [R3]
      // Non-interleaved plain transceivers ignore these two outputs
      path_select <= interleave & addr_q[2]; // [R4]
      exchanger_latch_enable <= ~(in_access & is_write & interleave & col_phase); // [R4]
    end
  end

endmodule

`default_nettype wire

//--- sim/cpu_bus_model.sv
`default_nettype none

module cpu_bus_model (
  // Clock
  input wire logic clk_sys,
  // Processor bus pins
  output logic [25:0] ad,
  output logic ale,
  output logic rd_n,
  output logic wr_n,
  output logic near_write_hint_n,
  output logic cs_n,
  output logic msel_n,
  output logic [3:0] byte_en_n,
  // Controller outputs watched
  input wire logic ack_n,
  input wire logic row_strobe_n,
  input wire logic [3:0] col_strobe_n,
  input wire logic [10:0] dram_address_out,
  input wire logic buffer_transmit,
  input wire logic path_select,
  input wire logic exchanger_latch_enable
);
  timeunit 1ns;
  timeprecision 100ps;
  int row_len, rc_gap, col_len;
  logic ack_seen, tx, path, hold;
  logic [10:0] a_row, a_col;

  // Idle bus: pull-ups lift the released lines
  task automatic idle();
    ad = '1;
    ale = 1'b0;
    rd_n = 1'b1;
    wr_n = 1'b1;
    near_write_hint_n = 1'b1;
    cs_n = 1'b1;
    msel_n = 1'b1;
    byte_en_n = 4'hF;
  endtask
  initial idle();

  // One bus cycle; strobes held until the acknowledge is sampled (30 edges at most), or for four clocks on mode writes
  task automatic cycle(input logic wr, md, sel, hn, input logic [25:0] a,
                       input logic [15:0] d);
    int i;
    row_len = 0;
    rc_gap = 0;
    col_len = 0;
    {ack_seen, tx, path, hold} = 4'h0;
    @(posedge clk_sys);
    #1;
    ad = a;
    ale = 1'b1;
    cs_n = ~sel; // Decoder: chip select, plus mode select on mode writes
    msel_n = ~md;
    byte_en_n = 4'h0;
    near_write_hint_n = hn;
    repeat (3) @(posedge clk_sys);
    #1;
    ale = 1'b0;
    rd_n = wr;
    wr_n = ~wr;
    ad = wr ? {10'h3FF, d} : '1; // Config sits on the low sixteen lines
    if (md) repeat (4) @(posedge clk_sys);
    for (i = 0; i < 30 && !md && !ack_seen; i++) begin
      @(posedge clk_sys);
      #1;
      if (!row_strobe_n) begin
        if (row_len == 0) a_row = dram_address_out;
        if (row_len == 1) a_col = dram_address_out;
        row_len++;
        if (col_strobe_n == 4'hF) rc_gap++;
        else col_len++;
        tx |= buffer_transmit;
        path |= path_select;
        hold |= !exchanger_latch_enable;
      end
      ack_seen = !ack_n;
    end
    // Release only after the edge that samples the acknowledge
    if (!md) @(posedge clk_sys);
    #1 idle();
    repeat (4) @(posedge clk_sys);
  endtask
endmodule

`default_nettype wire

//--- sim/dram_mode_config_asserts.sv
`default_nettype none

module dram_mode_config_asserts (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Watched outputs
  input wire logic ack_n,
  input wire logic row_strobe_n,
  input wire logic [3:0] col_strobe_n,
  input wire logic write_strobe_n,
  input wire logic buffer_transmit,
  input wire logic [3:0] byte_lane_buffer_enable_n,
  input wire logic path_select,
  input wire logic exchanger_latch_enable
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  // Strobe timing around an access
  a_ack_pulse: assert property (!ack_n |=> ack_n)
    else $error("acknowledge longer than one cycle");
  a_col_ack_align: assert property ($fell(ack_n) |->
    col_strobe_n == 4'hF && $past(col_strobe_n) != 4'hF)
    else $error("column strobe not released with acknowledge");
  a_ack_row_end: assert property ($fell(ack_n) |-> $rose(row_strobe_n))
    else $error("row strobe not released with acknowledge");
  a_col_width: assert property ($fell(col_strobe_n == 4'hF) |->
    (col_strobe_n != 4'hF)[*3]) else $error("column strobe too short");
  a_row_to_col: assert property ($fell(row_strobe_n) |->
    (col_strobe_n == 4'hF)[*2]) else $error("column strobe too early");
  a_row_min: assert property ($fell(row_strobe_n) |-> !row_strobe_n[*5])
    else $error("row strobe too short");
  a_col_in_row: assert property (col_strobe_n != 4'hF |-> !row_strobe_n)
    else $error("column strobe without row strobe");
  a_ack_bound: assert property ($fell(row_strobe_n) |-> ##[5:10] !ack_n)
    else $error("access did not end in time");
  // Data path controls
  a_lane_enable: assert property (col_strobe_n != 4'hF |->
    (byte_lane_buffer_enable_n & ~col_strobe_n) == 4'h0)
    else $error("strobed lane has its buffer off");
  a_dir_write: assert property (!write_strobe_n |-> buffer_transmit)
    else $error("write without transmit direction");
  a_latch_read: assert property (!buffer_transmit |-> exchanger_latch_enable)
    else $error("exchanger latch closed on a read");
  c_read: cover property ($fell(ack_n) && !buffer_transmit);
  c_write: cover property ($fell(ack_n) && buffer_transmit);
  c_path: cover property (path_select && !exchanger_latch_enable);
endmodule

bind dram_mode_config_datapath dram_mode_config_asserts i_dram_mode_config_asserts (.*);

`default_nettype wire

//--- sim/tb_top.sv
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys, srst, ale, rd_n, wr_n, near_write_hint_n, cs_n, msel_n, ack_n;
  logic row_strobe_n, write_strobe_n, buffer_transmit, path_select;
  logic exchanger_latch_enable;
  logic [25:0] ad;
  logic [3:0] byte_en_n, col_strobe_n, byte_lane_buffer_enable_n;
  logic [10:0] dram_address_out;
  int num_errors, tests_run;

  dram_mode_config_datapath i_dram_mode_config_datapath (.*);
  cpu_bus_model i_cpu_bus_model (.*);

  // Comparison and verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %0h, expected %0h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Bus helpers; a missing acknowledge ends the run
  task automatic cfg(input logic [15:0] d);
    i_cpu_bus_model.cycle(1'b1, 1'b1, 1'b1, 1'b1, 26'h0000000, d);
  endtask
  task automatic acc(input logic wr, hn, input logic [25:0] a, input int e, c);
    i_cpu_bus_model.cycle(wr, 1'b0, 1'b1, hn, a, 16'hA55A);
    if (!i_cpu_bus_model.ack_seen) begin
      num_errors++;
      conclude();
    end
    check(i_cpu_bus_model.row_len, e);
    check(i_cpu_bus_model.rc_gap, c);
    check(i_cpu_bus_model.tx, wr);
  endtask

  // Regular clock, equal phases
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  initial begin
    num_errors = 0;
    tests_run = 0;
    srst = 1'b1;
    repeat (5) @(posedge clk_sys);
    #1 srst = 1'b0;
    check({ack_n, row_strobe_n, col_strobe_n, byte_lane_buffer_enable_n,
      exchanger_latch_enable, path_select, buffer_transmit}, 32'h00001FFC);
    check({write_strobe_n, dram_address_out}, 32'h00000800);
    $display("test reset done");
    // Plain 256K page: row then column, swap one edge after row strobe
    cfg(16'h0000);
    acc(1'b0, 1'b1, 26'h0031F24, 5, 2);
    check(i_cpu_bus_model.a_row, 32'h00000063);
    check(i_cpu_bus_model.a_col, 32'h000001C9);
    check(i_cpu_bus_model.col_len, 3);
    check(i_cpu_bus_model.path, 1'b0);
    $display("test plain read done");
    // Not selected: the controller keeps quiet
    i_cpu_bus_model.cycle(1'b0, 1'b0, 1'b0, 1'b1, 26'h0031F24, 16'h0000);
    check(i_cpu_bus_model.row_len, 0);
    check(i_cpu_bus_model.ack_seen, 1'b0);
    $display("test deselect done");
    // Near writes fast with hint, slow without, slow when overridden
    acc(1'b1, 1'b0, 26'h0000100, 6, 2);
    acc(1'b1, 1'b1, 26'h0000100, 8, 2);
    cfg(16'h0008);
    acc(1'b1, 1'b0, 26'h0000100, 8, 2);
    $display("test near write done");
    // Longer row-to-column delay
    cfg(16'h0010);
    acc(1'b0, 1'b1, 26'h0000200, 7, 4);
    $display("test slow column done");
    // Larger pages move the row/column split up by one bit each
    cfg(16'h0001);
    acc(1'b0, 1'b1, 26'h0031F24, 5, 2);
    check(i_cpu_bus_model.a_row, 32'h00000031);
    check(i_cpu_bus_model.a_col, 32'h000003C9);
    cfg(16'h0002);
    acc(1'b0, 1'b1, 26'h0031F24, 5, 2);
    check(i_cpu_bus_model.a_row, 32'h00000018);
    check(i_cpu_bus_model.a_col, 32'h000007C9);
    $display("test page size done");
    // Interleaved write through exchangers
    cfg(16'h0004);
    acc(1'b1, 1'b1, 26'h0000004, 8, 2);
    check({i_cpu_bus_model.path, i_cpu_bus_model.hold}, 2'h3);
    $display("test interleave done");
    conclude();
  end
endmodule

`default_nettype wire
